// *** vcec_bank_mem.sv ***
// two-bank capture memory: capture writes one bank, host reads the other
`timescale 1ns/10ps
module vcec_bank_mem import vcec_pkg::*; #(
   parameter int DEPTH = MEM_DEPTH
) (
   input wire logic core_clk_i, // core clock
   vcec_mem_if.mem mem_if // write and read ports
);
   logic [DATA_W-1:0] store_q [2][DEPTH];

   // write lands at the edge, read is combinational in the same cycle
   always_ff @(posedge core_clk_i) begin
      if (mem_if.wr_en) begin
         store_q[mem_if.wr_bank][mem_if.wr_addr] <= mem_if.wr_data;
      end
   end

   // host read of its own bank
   assign mem_if.rd_data = store_q[mem_if.rd_bank][mem_if.rd_addr];
endmodule : vcec_bank_mem

// *** vcec_host_model.sv ***
// host processor model: register bus master for the capture block
`timescale 1ns/10ps
module vcec_host_model import vcec_pkg::*; (
   input wire logic core_clk_i, // core clock
   input wire logic [DATA_W-1:0] bus_rdata_i, // read data from block
   output logic [BUS_AW-1:0] bus_addr_o, // word address
   output logic [DATA_W-1:0] bus_wdata_o, // write data
   output logic bus_wr_o, // write strobe
   output logic bus_rd_o // read strobe
);
   // bus idle at time zero
   initial begin
      bus_addr_o = '0;
      bus_wdata_o = '0;
      bus_wr_o = 1'b0;
      bus_rd_o = 1'b0;
   end
   // one-cycle write; released data flips so stale values never look valid
   task automatic wr(input logic [BUS_AW-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk_i);
      bus_addr_o <= a;
      bus_wdata_o <= d;
      bus_wr_o <= 1'b1;
      @(posedge core_clk_i);
      bus_wr_o <= 1'b0;
      bus_wdata_o <= ~d;
   endtask : wr
   // one-cycle read, data taken in the cycle after the strobe
   task automatic rd(input logic [BUS_AW-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge core_clk_i);
      bus_addr_o <= a;
      bus_rd_o <= 1'b1;
      @(posedge core_clk_i);
      bus_rd_o <= 1'b0;
      #1;
      d = bus_rdata_i;
   endtask : rd
   // thresholds, corneal never below pupil
   task automatic set_thresh(input logic [3:0] p, input logic [3:0] c);
      wr(REG_THRESH, {8'h00, ((c < p) ? p : c), p});
   endtask : set_thresh
   // bank select on bit five beside the gain bits
   task automatic sel_bank(input logic b, input logic [3:0] g);
      wr(REG_CTRL, {10'h000, b, 1'b0, g});
   endtask : sel_bank
endmodule : vcec_host_model

// *** vcec_mem_if.sv ***
// carrier between the capture logic and the ping-pong bank memory
`timescale 1ns/10ps
interface vcec_mem_if #(parameter int AW = 10, parameter int DW = 16);
   logic wr_en;
   logic wr_bank;
   logic [AW-1:0] wr_addr;
   logic [DW-1:0] wr_data;
   logic rd_bank;
   logic [AW-1:0] rd_addr;
   logic [DW-1:0] rd_data;
   modport ctrl (output wr_en, wr_bank, wr_addr, wr_data, rd_bank, rd_addr, input rd_data);
   modport mem (input wr_en, wr_bank, wr_addr, wr_data, rd_bank, rd_addr, output rd_data);
endinterface : vcec_mem_if

// *** vcec_pkg.sv ***
// shared constants and types for the video contour event capture block
package vcec_pkg;
   // widths
   localparam int SAMPLE_W = 4;
   localparam int GAIN_W = 4;
   localparam int DATA_W = 16;
   localparam int BUS_AW = 11;
   localparam int MEM_AW = 10;
   localparam int MEM_DEPTH = 1024;
   localparam int COL_W = 10;
   localparam int ROW_W = 8;
   localparam int TBL_W = 12;
   localparam int IRQ_W = 3;
   // offset modulo-ten divider: counts 6..15
   localparam logic [3:0] DIV_PRESET = 4'h6;
   localparam logic [3:0] DIV_LAST = 4'hF;
   localparam logic [3:0] DIV_HIGH2 = 4'hB;
   // table address presets
   localparam logic [TBL_W-1:0] CORNEAL_PRESET = 12'hFFF;
   localparam logic [TBL_W-1:0] PUPIL_PRESET = 12'h000;
   localparam logic [TBL_W-1:0] TBL_ONE = 12'h001;
   // pixel column counter top
   localparam logic [COL_W-1:0] COL_LAST = 10'h217;
   // sync generator timing in divided-clock ticks and lines
   localparam int H_TOTAL_DEF = 127;
   localparam int H_BLANK_DEF = 20;
   localparam int H_DRIVE_DEF = 10;
   localparam int V_TOTAL_DEF = 262;
   localparam int V_BLANK_DEF = 7;
   localparam int V_DRIVE_DEF = 3;
   // register map, word addresses on the host port
   localparam logic [BUS_AW-1:0] MEM_SPAN = 11'h400;
   localparam logic [BUS_AW-1:0] REG_CTRL = 11'h400;
   localparam logic [BUS_AW-1:0] REG_THRESH = 11'h401;
   localparam logic [BUS_AW-1:0] REG_STATUS = 11'h402;
   localparam logic [BUS_AW-1:0] REG_MASK = 11'h403;
   localparam logic [BUS_AW-1:0] REG_PUPIL_ADDR = 11'h404;
   localparam logic [BUS_AW-1:0] REG_CORN_ADDR = 11'h405;
   // field positions
   localparam int CTRL_BANK_BIT = 5;
   localparam int THR_CORN_LSB = 4;
   localparam int ST_PUPIL = 0;
   localparam int ST_CORN = 1;
   localparam int ST_FRAME = 2;
   localparam int VMARK_BIT = 15;
   localparam logic [DATA_W-1:0] EOT_WORD = 16'hFFFF;
   // pixel classes
   localparam logic [1:0] CLS_NONE = 2'h0;
   localparam logic [1:0] CLS_PUPIL = 2'h1;
   localparam logic [1:0] CLS_CORN = 2'h2;
   // capture sequencer
   typedef enum logic [5:0] {
      CAP_ACTIVE = 6'h01,
      CAP_MARK_C = 6'h02,
      CAP_MARK_P = 6'h04,
      CAP_EOT_C = 6'h08,
      CAP_EOT_P = 6'h10,
      CAP_BLANK = 6'h20
   } vcec_cap_type;
endpackage : vcec_pkg

// *** vcec_top.sv ***
// video contour event capture: clock divider, sync generator, event capture, host port
// What this block does
// - mod-ten divider makes fast and slow ticks
// - inverted fast divider output is system clock
// - slow divider output clocks the sync generator
// - host gets copies of the drive signals
// - one four-bit video sample per system clock
// - four software bits set video gain
// - sample classed none, pupil or corneal
// - class changes raise pupil or corneal events
// - corneal beats pupil, direct jump logs corneal
// - each event stores current pixel column
// - two 1K by 16 banks, ping-pong
// - host sees only its selected bank
// - memory writes and reads share one clock
// - corneal counter up from FFF, pupil down
// - column counts to 535, row per line
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module vcec_top import vcec_pkg::*; #(
   parameter int H_TOTAL = H_TOTAL_DEF, // slow ticks per line
   parameter int H_BLANK = H_BLANK_DEF, // slow ticks of line blanking
   parameter int H_DRIVE = H_DRIVE_DEF, // slow ticks of line drive
   parameter int V_TOTAL = V_TOTAL_DEF, // lines per field
   parameter int V_BLANK = V_BLANK_DEF, // lines of field blanking
   parameter int V_DRIVE = V_DRIVE_DEF // lines of field drive
) (
   input wire logic core_clk_i, // core clock, stands for the oscillator
   input wire logic rst_b_i, // async reset, active low
   input wire logic [SAMPLE_W-1:0] video_sample_i, // converter output pins
   input wire logic [BUS_AW-1:0] bus_addr_i, // host word address
   input wire logic [DATA_W-1:0] bus_wdata_i, // host write data
   input wire logic bus_wr_i, // host write strobe
   input wire logic bus_rd_i, // host read strobe
   output logic [DATA_W-1:0] bus_rdata_o, // read data, cycle after strobe
   output logic irq_o, // level interrupt
   output logic sys_clk_o, // divided system clock
   output logic sync_clk_o, // divided sync clock
   output logic hdrive_o, // line drive to camera
   output logic vdrive_o, // field drive to camera
   output logic csync_o, // composite sync
   output logic cblank_o, // composite blanking
   output logic host_hdrive_o, // line drive copy for host
   output logic host_vdrive_o, // field drive copy for host
   output logic [GAIN_W-1:0] gain_o, // gain switch bits
   output logic pupil_transition_flag_o, // pupil event logged
   output logic corneal_transition_flag_o // corneal event logged
);
   typedef struct packed {
      logic [3:0] div_cnt;
      logic sys_clk;
      logic sync_clk;
      logic [7:0] h_tick;
      logic [8:0] v_line;
      logic hdrive;
      logic vdrive;
      logic csync;
      logic hblank;
      logic vblank;
      logic cblank;
      logic hb_last;
      logic [SAMPLE_W-1:0] smp1;
      logic [SAMPLE_W-1:0] smp2;
      logic [SAMPLE_W-1:0] smp3;
      logic [SAMPLE_W-1:0] smp_ok;
      logic [1:0] prev_cls;
      logic [COL_W-1:0] pixel_column_count;
      logic [ROW_W-1:0] line_row_count;
      logic line_had_p;
      logic line_had_c;
      logic frame_done;
      vcec_cap_type cap_st;
      logic [TBL_W-1:0] p_addr;
      logic [TBL_W-1:0] c_addr;
      logic pflag;
      logic cflag;
      logic mem_we;
      logic mem_bank;
      logic [MEM_AW-1:0] mem_addr;
      logic [DATA_W-1:0] mem_data;
      logic [GAIN_W-1:0] gain;
      logic bank_sel;
      logic [SAMPLE_W-1:0] pthr;
      logic [SAMPLE_W-1:0] cthr;
      logic [IRQ_W-1:0] status;
      logic [IRQ_W-1:0] mask;
      logic irq;
      logic [DATA_W-1:0] rdata;
   } vcec_state_type;

   vcec_state_type s_q;
   vcec_state_type s_d;
   logic [1:0] cls;
   logic logging;
   vcec_mem_if #(.AW(MEM_AW), .DW(DATA_W)) mem_if ();

   // memory hookup
   assign mem_if.wr_en = s_q.mem_we;
   assign mem_if.wr_bank = s_q.mem_bank;
   assign mem_if.wr_addr = s_q.mem_addr;
   assign mem_if.wr_data = s_q.mem_data;
   assign mem_if.rd_bank = s_q.bank_sel;
   assign mem_if.rd_addr = bus_addr_i[MEM_AW-1:0];

   vcec_bank_mem #(.DEPTH(MEM_DEPTH)) u_mem (
      .core_clk_i (core_clk_i),
      .mem_if (mem_if.mem)
   );

   // next-state logic
   always_comb begin
      logic sys_tick;
      logic sync_tick;
      logic corn_evt;
      logic pup_evt;
      logic frame_evt;
      logic [IRQ_W-1:0] clr;
      logic [TBL_W-1:0] c_next;
      logic [TBL_W-1:0] p_next;
      logic [DATA_W-1:0] hword;
      logic [DATA_W-1:0] vword;
      sys_tick = s_q.sys_clk;
      sync_tick = (s_q.div_cnt == DIV_LAST);
      corn_evt = 1'b0;
      pup_evt = 1'b0;
      frame_evt = 1'b0;
      clr = '0;
      c_next = s_q.c_addr + TBL_ONE;
      p_next = s_q.p_addr - TBL_ONE;
      hword = '0;
      hword[COL_W-1:0] = s_q.pixel_column_count;
      vword = '0;
      vword[VMARK_BIT] = 1'b1;
      vword[ROW_W-1:0] = s_q.line_row_count;
      s_d = s_q;
      // offset modulo-ten divider and its two outputs
      s_d.div_cnt = sync_tick ? DIV_PRESET : s_q.div_cnt + 4'h1;
      s_d.sys_clk = ~s_d.div_cnt[0];
      s_d.sync_clk = (s_d.div_cnt >= DIV_HIGH2);
      // sync generator steps on the slow tick
      if (sync_tick) begin
         if (int'(s_q.h_tick) == H_TOTAL - 1) begin
            s_d.h_tick = '0;
            s_d.v_line = (int'(s_q.v_line) == V_TOTAL - 1) ? '0 : s_q.v_line + 9'h001;
         end else begin
            s_d.h_tick = s_q.h_tick + 8'h01;
         end
      end
      s_d.hblank = int'(s_d.h_tick) < H_BLANK;
      s_d.vblank = int'(s_d.v_line) < V_BLANK;
      s_d.hdrive = int'(s_d.h_tick) < H_DRIVE;
      s_d.vdrive = int'(s_d.v_line) < V_DRIVE;
      s_d.csync = s_d.hdrive | s_d.vdrive;
      s_d.cblank = s_d.hblank | s_d.vblank;
      // row counter: advances at line blanking, cleared in field blanking
      if (sync_tick && int'(s_q.h_tick) == H_TOTAL - 1) begin
         s_d.line_row_count = s_d.vblank ? '0 : s_q.line_row_count + 8'h01;
      end
      // three-stage pin synchroniser, accepted when stages two and three agree
      s_d.smp1 = video_sample_i;
      s_d.smp2 = s_q.smp1;
      s_d.smp3 = s_q.smp2;
      if (s_q.smp2 == s_q.smp3) begin
         s_d.smp_ok = s_q.smp3;
      end
      // classify against the two thresholds
      if (s_q.smp_ok > s_q.cthr) begin
         cls = CLS_CORN;
      end else if (s_q.smp_ok > s_q.pthr) begin
         cls = CLS_PUPIL;
      end else begin
         cls = CLS_NONE;
      end
      corn_evt = (cls == CLS_CORN) != (s_q.prev_cls == CLS_CORN);
      pup_evt = !corn_evt && (cls != s_q.prev_cls);
      logging = sys_tick && !s_q.hblank && !s_q.vblank && (s_q.cap_st == CAP_ACTIVE);
      // one sample per system clock, column counter
      if (sys_tick) begin
         s_d.prev_cls = cls;
         s_d.hb_last = s_q.hblank;
         if (s_q.hblank) begin
            s_d.pixel_column_count = '0;
         end else if (s_q.pixel_column_count < COL_LAST) begin
            s_d.pixel_column_count = s_q.pixel_column_count + 10'h001;
         end
      end
      // capture sequencer and table writes
      s_d.pflag = 1'b0;
      s_d.cflag = 1'b0;
      s_d.mem_we = 1'b0;
      if (sys_tick) begin
         unique case (s_q.cap_st)
            CAP_ACTIVE: begin
               if (s_q.hblank && !s_q.hb_last) begin
                  s_d.cap_st = CAP_MARK_C;
               end else if (logging && corn_evt) begin
                  s_d.cflag = 1'b1;
                  s_d.line_had_c = 1'b1;
                  s_d.mem_we = 1'b1;
                  s_d.mem_addr = c_next[MEM_AW-1:0];
                  s_d.mem_data = hword;
                  s_d.c_addr = c_next;
               end else if (logging && pup_evt) begin
                  s_d.pflag = 1'b1;
                  s_d.line_had_p = 1'b1;
                  s_d.mem_we = 1'b1;
                  s_d.mem_addr = p_next[MEM_AW-1:0];
                  s_d.mem_data = hword;
                  s_d.p_addr = p_next;
               end
            end
            CAP_MARK_C: begin
               if (s_q.line_had_c) begin
                  s_d.mem_we = 1'b1;
                  s_d.mem_addr = c_next[MEM_AW-1:0];
                  s_d.mem_data = vword;
                  s_d.c_addr = c_next;
               end
               s_d.cap_st = CAP_MARK_P;
            end
            CAP_MARK_P: begin
               if (s_q.line_had_p) begin
                  s_d.mem_we = 1'b1;
                  s_d.mem_addr = p_next[MEM_AW-1:0];
                  s_d.mem_data = vword;
                  s_d.p_addr = p_next;
               end
               s_d.line_had_c = 1'b0;
               s_d.line_had_p = 1'b0;
               s_d.cap_st = (s_q.vblank && !s_q.frame_done) ? CAP_EOT_C : CAP_BLANK;
            end
            CAP_EOT_C: begin
               s_d.mem_we = 1'b1;
               s_d.mem_addr = c_next[MEM_AW-1:0];
               s_d.mem_data = EOT_WORD;
               s_d.cap_st = CAP_EOT_P;
            end
            CAP_EOT_P: begin
               s_d.mem_we = 1'b1;
               s_d.mem_addr = p_next[MEM_AW-1:0];
               s_d.mem_data = EOT_WORD;
               s_d.c_addr = CORNEAL_PRESET;
               s_d.p_addr = PUPIL_PRESET;
               s_d.frame_done = 1'b1;
               frame_evt = 1'b1;
               s_d.cap_st = CAP_BLANK;
            end
            CAP_BLANK: begin
               if (!s_q.hblank) begin
                  s_d.cap_st = CAP_ACTIVE;
               end
            end
         endcase
      end
      if (!s_q.vblank) begin
         s_d.frame_done = 1'b0;
      end
      // host writes
      if (bus_wr_i) begin
         unique case (bus_addr_i)
            REG_CTRL: begin
               s_d.gain = bus_wdata_i[GAIN_W-1:0];
               s_d.bank_sel = bus_wdata_i[CTRL_BANK_BIT];
            end
            REG_THRESH: begin
               s_d.pthr = bus_wdata_i[SAMPLE_W-1:0];
               s_d.cthr = bus_wdata_i[THR_CORN_LSB +: SAMPLE_W];
            end
            REG_STATUS: clr = bus_wdata_i[IRQ_W-1:0];
            REG_MASK: s_d.mask = bus_wdata_i[IRQ_W-1:0];
            default: ;
         endcase
      end
      // capture always writes the bank the host is not looking at
      s_d.mem_bank = ~s_d.bank_sel;
      // host reads, data only in the following cycle
      s_d.rdata = '0;
      if (bus_rd_i) begin
         if (bus_addr_i < MEM_SPAN) begin
            s_d.rdata = mem_if.rd_data;
         end else begin
            unique case (bus_addr_i)
               REG_CTRL: begin
                  s_d.rdata[GAIN_W-1:0] = s_q.gain;
                  s_d.rdata[CTRL_BANK_BIT] = s_q.bank_sel;
               end
               REG_THRESH: begin
                  s_d.rdata[SAMPLE_W-1:0] = s_q.pthr;
                  s_d.rdata[THR_CORN_LSB +: SAMPLE_W] = s_q.cthr;
               end
               REG_STATUS: s_d.rdata[IRQ_W-1:0] = s_q.status;
               REG_MASK: s_d.rdata[IRQ_W-1:0] = s_q.mask;
               REG_PUPIL_ADDR: s_d.rdata[TBL_W-1:0] = s_q.p_addr;
               REG_CORN_ADDR: s_d.rdata[TBL_W-1:0] = s_q.c_addr;
               default: ;
            endcase
         end
      end
      // sticky status, set wins over write-one-to-clear
      s_d.status = (s_q.status & ~clr) | {frame_evt, s_d.cflag, s_d.pflag};
      s_d.irq = |(s_d.status & s_d.mask);
   end

   // state register
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '0; // previous class starts as none
         s_q.div_cnt <= DIV_PRESET;
         s_q.sys_clk <= 1'b1;
         s_q.cap_st <= CAP_BLANK;
         s_q.c_addr <= CORNEAL_PRESET;
         s_q.mem_bank <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign bus_rdata_o = s_q.rdata;
   assign irq_o = s_q.irq;
   assign sys_clk_o = s_q.sys_clk;
   assign sync_clk_o = s_q.sync_clk;
   assign hdrive_o = s_q.hdrive;
   assign vdrive_o = s_q.vdrive;
   assign csync_o = s_q.csync;
   assign cblank_o = s_q.cblank;
   assign host_hdrive_o = s_q.hdrive;
   assign host_vdrive_o = s_q.vdrive;
   assign gain_o = s_q.gain;
   assign pupil_transition_flag_o = s_q.pflag;
   assign corneal_transition_flag_o = s_q.cflag;

   // checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);

   a_div_wrap: assert property (s_q.div_cnt == DIV_LAST |=> s_q.div_cnt == DIV_PRESET)
      else $error("divider did not reload");
   a_sync_duty: assert property (s_q.div_cnt == DIV_HIGH2 |-> sync_clk_o [*5] ##1 !sync_clk_o [*5])
      else $error("slow divider output not five high five low");
   a_sys_toggle: assert property ($past(rst_b_i) |-> sys_clk_o != $past(sys_clk_o))
      else $error("system clock output did not toggle");
   a_sync_hold: assert property (s_q.div_cnt != DIV_LAST |=> $stable(s_q.h_tick))
      else $error("sync generator stepped off the slow tick");
   a_drive_blank: assert property (host_hdrive_o |-> cblank_o && hdrive_o)
      else $error("host drive copy outside blanking");
   a_sample_hold: assert property (!sys_clk_o |=> $stable(s_q.prev_cls))
      else $error("sample taken off the system clock");
   a_gain_path: assert property (bus_wr_i && bus_addr_i == REG_CTRL |=> gain_o == $past(bus_wdata_i[GAIN_W-1:0]))
      else $error("gain bits not taken from control write");
   a_corn_class: assert property (sys_clk_o && s_q.smp_ok > s_q.cthr |=> s_q.prev_cls == CLS_CORN)
      else $error("sample above corneal threshold not class two");
   a_no_change: assert property (logging && cls == s_q.prev_cls |=> !pupil_transition_flag_o && !corneal_transition_flag_o)
      else $error("event raised with no class change");
   a_jump_prio: assert property (logging && s_q.prev_cls == CLS_NONE && cls == CLS_CORN
      |=> corneal_transition_flag_o && !pupil_transition_flag_o)
      else $error("direct jump did not log corneal only");
   a_event_store: assert property (pupil_transition_flag_o || corneal_transition_flag_o
      |-> mem_if.wr_en && !mem_if.wr_data[VMARK_BIT])
      else $error("event without coordinate write");
   a_bank_split: assert property (mem_if.wr_en |-> mem_if.wr_bank != mem_if.rd_bank)
      else $error("capture wrote the host bank");
   a_corn_step: assert property (corneal_transition_flag_o
      |-> s_q.c_addr == $past(s_q.c_addr) + TBL_ONE && $stable(s_q.p_addr))
      else $error("corneal counter step wrong");
   a_col_range: assert property (s_q.pixel_column_count <= COL_LAST)
      else $error("column counter beyond its top");
   a_set_wins: assert property (corneal_transition_flag_o |-> s_q.status[ST_CORN] ##1 irq_o == |(s_q.status & s_q.mask))
      else $error("status set lost or interrupt wrong");
endmodule : vcec_top

// *** vcec_top_tb.sv ***
// self-checking testbench for the video contour event capture block
`timescale 1ns/10ps
module vcec_top_tb import vcec_pkg::*; ();
   logic core_clk, rst_b, wr, rd, irq, sys_clk, sync_clk, hd, vd, cs, cb, hhd, hvd, pf, cf;
   logic [SAMPLE_W-1:0] video;
   logic [BUS_AW-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, d, pa, ca, e;
   logic [GAIN_W-1:0] gain;
   int fail_count = 0;
   int tests_run = 0;
   int p, c, n0, n1, n2, n3, n4, n5;
   logic [3:0] smp_t [8] = '{4'h4, 4'h9, 4'hA, 4'h3, 4'h0, 4'hF, 4'h9, 4'h3};
   logic ep_t [8] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   logic ec_t [8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
   // short sync timing: 80 core clocks a line, 6 lines a field, field drive left at its default
   vcec_top #(.H_TOTAL(8), .H_BLANK(2), .H_DRIVE(1), .V_TOTAL(6), .V_BLANK(2)) dut_u (
      .core_clk_i(core_clk), .rst_b_i(rst_b), .video_sample_i(video), .bus_addr_i(addr),
      .bus_wdata_i(wdata), .bus_wr_i(wr), .bus_rd_i(rd), .bus_rdata_o(rdata), .irq_o(irq),
      .sys_clk_o(sys_clk), .sync_clk_o(sync_clk), .hdrive_o(hd), .vdrive_o(vd), .csync_o(cs),
      .cblank_o(cb), .host_hdrive_o(hhd), .host_vdrive_o(hvd), .gain_o(gain),
      .pupil_transition_flag_o(pf), .corneal_transition_flag_o(cf));
   vcec_host_model host_u (.core_clk_i(core_clk), .bus_rdata_i(rdata), .bus_addr_o(addr),
      .bus_wdata_o(wdata), .bus_wr_o(wr), .bus_rd_o(rd));
   // core clock, 8 ns period
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // word comparison
   task automatic check_w(input string nm, input logic [15:0] ex, input logic [15:0] got);
      tests_run++;
      if (got !== ex) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, ex, got);
      end
   endtask : check_w
   // bit comparison
   task automatic check_b(input string nm, input logic ex, input logic got);
      check_w(nm, {15'h0000, ex}, {15'h0000, got});
   endtask : check_b
   // counts and verdict, then end of run
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict
   // step to just after the next edge
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask : tick
   // count flag pulses over n cycles, both at once counted in n5
   task automatic watch(input int n, output int np, output int nc);
      np = 0;
      nc = 0;
      for (int k = 0; k < n; k++) begin
         tick();
         np += (pf === 1'b1);
         nc += (cf === 1'b1);
         n5 += (pf === 1'b1 && cf === 1'b1);
      end
   endtask : watch
   // wait for the end of blanking, bounded
   task automatic wait_active();
      logic was;
      was = 1'b0;
      for (int k = 0; k < 1000; k++) begin
         tick();
         if (was === 1'b1 && cb === 1'b0) return;
         was = cb;
      end
      fail_count++;
      $display("Error wait_active expected blanking end seen none");
      print_verdict();
   endtask : wait_active
   // main sequence
   initial begin
      rst_b = 1'b0;
      video = '0;
      n5 = 0;
      repeat (5) @(posedge core_clk);
      check_b("sys_clk_rst", 1'b1, sys_clk);
      rst_b <= 1'b1;
      watch(200, p, c);
      check_w("quiet_flags", 16'h0000, 16'(p + c));
      host_u.rd(REG_PUPIL_ADDR, d);
      check_w("pupil_addr_rst", 16'h0000, d);
      host_u.rd(REG_CORN_ADDR, d);
      check_w("corn_addr_rst", 16'h0FFF, d);
      host_u.rd(11'h7FF, d);
      check_w("unmapped", 16'h0000, d);
      // divider outputs over 20 core clocks
      n0 = 0;
      n1 = 0;
      for (int k = 0; k < 20; k++) begin
         e[0] = sys_clk;
         tick();
         n0 += (sys_clk !== e[0]);
         n1 += (sync_clk === 1'b1);
      end
      check_w("sys_toggles", 16'h0014, 16'(n0));
      check_w("sync_high", 16'h000A, 16'(n1));
      // sync outputs over one whole field
      {n0, n1, n2, n3, n4} = '0;
      for (int k = 0; k < 480; k++) begin
         tick();
         n0 += (hd === 1'b1);
         n1 += (vd === 1'b1);
         n2 += (cs === 1'b1);
         n3 += (cb === 1'b1);
         n4 += (hhd !== hd || hvd !== vd);
      end
      check_w("hdrive_high", 16'h003C, 16'(n0));
      check_w("vdrive_high", 16'h00F0, 16'(n1));
      check_w("csync_high", 16'h010E, 16'(n2));
      check_w("cblank_high", 16'h00F0, 16'(n3));
      check_w("host_drive", 16'h0000, 16'(n4));
      host_u.sel_bank(1'b1, 4'h5);
      tick();
      check_w("gain", 16'h0005, {12'h000, gain});
      host_u.set_thresh(4'h3, 4'h9);
      host_u.wr(REG_MASK, 16'h0002);
      // at most one class change per active line, expected flags and counter steps
      for (int i = 0; i < 8; i++) begin
         wait_active();
         host_u.rd(REG_PUPIL_ADDR, pa);
         host_u.rd(REG_CORN_ADDR, ca);
         @(posedge core_clk);
         video <= smp_t[i];
         watch(16, p, c);
         check_w("pupil_evt", {15'h0000, ep_t[i]}, 16'(p));
         check_w("corn_evt", {15'h0000, ec_t[i]}, 16'(c));
         host_u.rd(REG_PUPIL_ADDR, d);
         check_w("pupil_addr", {4'h0, 12'(pa[11:0] - {11'h000, ep_t[i]})}, d);
         host_u.rd(REG_CORN_ADDR, d);
         check_w("corn_addr", {4'h0, 12'(ca[11:0] + {11'h000, ec_t[i]})}, d);
         if (i == 2) begin
            host_u.sel_bank(1'b0, 4'h5);
            host_u.rd({1'b0, d[9:0]}, e);
            check_b("corn_entry", 1'b1, e[15:10] === 6'h00 && e[9:0] < 10'h028);
            host_u.sel_bank(1'b1, 4'h5);
         end
      end
      check_w("both_flags", 16'h0000, 16'(n5));
      // interrupt raise, mask, clear
      tick();
      check_b("irq_set", 1'b1, irq);
      host_u.rd(REG_STATUS, d);
      check_b("status_corn", 1'b1, d[ST_CORN]);
      host_u.wr(REG_MASK, 16'h0000);
      tick();
      check_b("irq_masked", 1'b0, irq);
      host_u.wr(REG_MASK, 16'h0002);
      tick();
      check_b("irq_unmasked", 1'b1, irq);
      host_u.wr(REG_STATUS, 16'h0002);
      tick();
      check_b("irq_cleared", 1'b0, irq);
      print_verdict();
   end
endmodule : vcec_top_tb
